// *** sadc_pkg.sv ***
package sadc_pkg;

    // Address word layout
    localparam int ADDR_BITS      = 10;
    localparam int SHIFT_BITS     = 9;
    localparam int PAIR_GROUPS    = 5;
    localparam int LINES_PER_PAIR = 4;
    localparam int DEC_LINES      = PAIR_GROUPS * LINES_PER_PAIR;
    localparam int MAX_LOADS      = 32;
    localparam int SAMPLE_W       = 8;

    // Reset value of the storage register; no channel may use it
    localparam logic [ADDR_BITS-1:0] STORE_RST = 10'h3ff;
    localparam logic [ADDR_BITS-1:0] SHIFT_RST = 10'h000;

    // Decode line order inside one group: 00, 10, 01, 11 (first bit, second bit)
    localparam logic [1:0] LINE_00 = 2'h0;
    localparam logic [1:0] LINE_10 = 2'h1;
    localparam logic [1:0] LINE_01 = 2'h2;
    localparam logic [1:0] LINE_11 = 2'h3;

    // Default amplitude thresholds on the signed sample scale
    localparam logic [SAMPLE_W-1:0] BIT_TH_DEF   = 8'h18;
    localparam logic [SAMPLE_W-1:0] SYNC_ON_DEF  = 8'h40;
    localparam logic [SAMPLE_W-1:0] SYNC_OFF_DEF = 8'h30;

    // Timing
    localparam int CLK_PERIOD_NS    = 8;
    localparam int MATCH_PULSE_NS   = 200;
    localparam int MATCH_PULSE_CYC  = (MATCH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MATCH_CNT_W      = 6;

    // Recovered pulse outputs of the input stage
    typedef struct packed {
        logic one;
        logic zero;
        logic bit_clk;
        logic sync;
    } sadc_pulse_s;

    // Channel switch sequence, Gray coded along the path
    typedef enum logic [1:0] {
        CH_TRACK   = 2'b00,
        CH_BREAK   = 2'b01,
        CH_SAMPLE  = 2'b11,
        CH_RELEASE = 2'b10
    } sadc_ch_e;

    // Switch drive of one channel
    typedef struct packed {
        logic xdcr_conn;
        logic amp_conn;
        logic match;
    } sadc_sw_s;

endpackage : sadc_pkg

// *** sadc_core.sv ***
`timescale 1ns/1ns
module sadc_core
    import sadc_pkg::*;
#(
    parameter int                            NUM_CH   = 10,
    parameter int                            GROUP_CH = 5,
    parameter logic [NUM_CH*ADDR_BITS-1:0]   CH_CODES = {10'h009, 10'h008, 10'h007, 10'h006, 10'h005,
                                                          10'h004, 10'h003, 10'h002, 10'h001, 10'h000},
    parameter logic [SAMPLE_W-1:0]           BIT_TH   = BIT_TH_DEF,
    parameter logic [SAMPLE_W-1:0]           SYNC_ON  = SYNC_ON_DEF,
    parameter logic [SAMPLE_W-1:0]           SYNC_OFF = SYNC_OFF_DEF
) (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst_b,
    // Digitised address line, signed, asynchronous to ref_clk
    input  wire logic [SAMPLE_W-1:0]         addr_sample,
    // Recovered pulses
    output sadc_pulse_s                      rx_pulse,
    // Stored address and active-low decode lines
    output logic [ADDR_BITS-1:0]             stored_addr,
    output logic [DEC_LINES-1:0]             decode_bus_n,
    output logic                             addr_load,
    // Channel switch drives
    output sadc_sw_s [NUM_CH-1:0]            ch_sw,
    // Open-drain shared match line
    output logic                             match_line_o,
    output logic                             match_line_oe_n
);

    // Refuse settings the decode lines or grouping cannot serve
    if (NUM_CH < 1 || NUM_CH > MAX_LOADS || (NUM_CH % GROUP_CH) != 0) begin : g_chk_ch
        $error("sadc_core: NUM_CH must be 1..32 and a multiple of GROUP_CH");
    end
    if (SYNC_OFF >= SYNC_ON || BIT_TH >= SYNC_OFF) begin : g_chk_th
        $error("sadc_core: thresholds must satisfy BIT_TH < SYNC_OFF < SYNC_ON");
    end
    for (genvar c = 0; c < NUM_CH; c++) begin : g_chk_code
        if (CH_CODES[c*ADDR_BITS +: ADDR_BITS] == STORE_RST) begin : g_bad
            $error("sadc_core: a channel code equals the reset value");
        end
    end

    // Whole module state
    typedef struct packed {
        logic [SAMPLE_W-1:0]    s1;
        logic [SAMPLE_W-1:0]    s2;
        logic [SAMPLE_W-1:0]    s3;
        logic [SAMPLE_W-1:0]    smp;
        sadc_pulse_s            pulse;
        logic                   in_bit;
        logic                   pol;
        logic                   sync_seen;
        logic [SHIFT_BITS-1:0]  shift;
        logic [ADDR_BITS-1:0]   store;
        logic [DEC_LINES-1:0]   dec_n;
        logic                   load;
        sadc_ch_e [NUM_CH-1:0]  ch;
        logic [MATCH_CNT_W-1:0] mcnt;
    } sadc_state_s;

    sadc_state_s st_q;
    sadc_state_s st_d;

    // Active-low decode of one stored value onto the twenty lines
    function automatic logic [DEC_LINES-1:0] decode_lines(input logic [ADDR_BITS-1:0] a);
        logic [DEC_LINES-1:0] l;
        logic [1:0]           sel;
        l = '1;
        for (int g = 0; g < PAIR_GROUPS; g++) begin
            // Group 0 holds the leftmost pair, sync bit first
            case ({a[ADDR_BITS-1-2*g], a[ADDR_BITS-2-2*g]})
                2'b00:   sel = LINE_00;
                2'b10:   sel = LINE_10;
                2'b01:   sel = LINE_01;
                default: sel = LINE_11;
            endcase
            l[g*LINES_PER_PAIR + int'(sel)] = 1'b0;
        end
        return l;
    endfunction : decode_lines

    // Five-input decoder: the one tapped line of each group must be low
    function automatic logic chan_match(input logic [DEC_LINES-1:0] l, input logic [ADDR_BITS-1:0] code);
        logic [DEC_LINES-1:0] tap;
        tap = ~decode_lines(code);
        return (l & tap) == '0;
    endfunction : chan_match

    // Combinational views of the accepted sample and of the stored decode lines
    logic [SAMPLE_W-1:0] mag;
    logic                one_lvl;
    logic                zero_lvl;
    logic                bit_lvl;
    logic [NUM_CH-1:0]   hit;

    always_comb begin
        // Rectify so both sync polarities hit the same threshold
        mag      = st_q.smp[SAMPLE_W-1] ? SAMPLE_W'(-st_q.smp) : st_q.smp;
        one_lvl  = !st_q.smp[SAMPLE_W-1] && (st_q.smp >= BIT_TH);
        zero_lvl = st_q.smp[SAMPLE_W-1] && (mag >= BIT_TH);
        bit_lvl  = one_lvl | zero_lvl;
        for (int c = 0; c < NUM_CH; c++) begin
            hit[c] = chan_match(st_q.dec_n, CH_CODES[c*ADDR_BITS +: ADDR_BITS]);
        end
    end

    // Next-state logic
    always_comb begin
        st_d      = st_q;
        st_d.load = 1'b0;

        // Three-stage pin capture; a new word counts once stages two and three agree
        st_d.s1 = addr_sample;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.smp = st_q.s3;
        end

        // Separate positive-going pulses, no timing assumption on rate
        st_d.pulse.one     = one_lvl;
        st_d.pulse.zero    = zero_lvl;
        st_d.pulse.bit_clk = bit_lvl;

        // Sync with hysteresis: set above the on level, drop only below off
        if (mag >= SYNC_ON) begin
            st_d.pulse.sync = 1'b1;
        end else if (mag < SYNC_OFF) begin
            st_d.pulse.sync = 1'b0;
        end

        // Track one received pulse; its value is taken at its start, its sync is settled at its end
        st_d.in_bit = bit_lvl;
        if (bit_lvl && !st_q.in_bit) begin
            st_d.pol       = one_lvl;
            st_d.sync_seen = 1'b0;
        end
        if (st_q.pulse.sync) begin
            st_d.sync_seen = 1'b1;
        end

        // Bit ends: the recovered bit clock has fallen
        if (st_q.in_bit && !bit_lvl) begin
            if (st_q.sync_seen || st_q.pulse.sync) begin
                // Tenth bit leads, nine shifted bits follow; all ten in one transfer
                st_d.store = {st_q.pol, st_q.shift};
                st_d.dec_n = decode_lines({st_q.pol, st_q.shift});
                st_d.load  = 1'b1;
            end else begin
                // Shift the new bit in at the right; older bits move one place left
                st_d.shift = {st_q.shift[SHIFT_BITS-2:0], st_q.pol};
            end
        end
        // Otherwise store and dec_n keep their values until the next sync

        // Per-channel switch sequence
        for (int c = 0; c < NUM_CH; c++) begin
            case (st_q.ch[c])
                CH_TRACK: begin
                    if (hit[c] && st_q.load) begin
                        st_d.ch[c] = CH_BREAK;
                    end
                end
                CH_BREAK: begin
                    st_d.ch[c] = CH_SAMPLE;
                end
                CH_SAMPLE: begin
                    // One address period: leave on the next load
                    if (st_q.load) begin
                        st_d.ch[c] = CH_RELEASE;
                    end
                end
                CH_RELEASE: begin
                    st_d.ch[c] = CH_TRACK;
                end
                default: begin
                    st_d.ch[c] = CH_TRACK;
                end
            endcase
        end

        // Shared match line: fixed low pulse per matching address
        if (st_q.load && (hit != '0)) begin
            st_d.mcnt = MATCH_CNT_W'(MATCH_PULSE_CYC);
        end else if (st_q.mcnt != '0) begin
            st_d.mcnt = st_q.mcnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q       <= '0;
            st_q.store <= STORE_RST;
            st_q.dec_n <= decode_lines(STORE_RST);
            st_q.shift <= SHIFT_RST[SHIFT_BITS-1:0];
            for (int c = 0; c < NUM_CH; c++) begin
                st_q.ch[c] <= CH_TRACK;
            end
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs from the state register; match_line_o is tied low
    always_comb begin
        rx_pulse        = st_q.pulse;
        stored_addr     = st_q.store;
        decode_bus_n    = st_q.dec_n;
        addr_load       = st_q.load;
        match_line_o    = 1'b0;
        match_line_oe_n = (st_q.mcnt == '0);
        for (int c = 0; c < NUM_CH; c++) begin
            // Transducer side closed only while tracking; amplifier only in sample
            ch_sw[c].xdcr_conn = (st_q.ch[c] == CH_TRACK);
            ch_sw[c].amp_conn  = (st_q.ch[c] == CH_SAMPLE);
            ch_sw[c].match     = (st_q.ch[c] == CH_BREAK) || (st_q.ch[c] == CH_SAMPLE);
        end
    end

endmodule : sadc_core

// *** sadc_core_props.sv ***
`timescale 1ns/1ns
module sadc_core_props
    import sadc_pkg::*;
#(
    parameter int                          NUM_CH   = 10,
    parameter logic [NUM_CH*ADDR_BITS-1:0] CH_CODES = '0
) (
    // Clock, reset and line
    input wire logic                 ref_clk,
    input wire logic                 rst_b,
    input wire logic [SAMPLE_W-1:0]  addr_sample,
    // Observed outputs
    input wire sadc_pulse_s          rx_pulse,
    input wire logic [ADDR_BITS-1:0] stored_addr,
    input wire logic [DEC_LINES-1:0] decode_bus_n,
    input wire logic                 addr_load,
    input wire sadc_sw_s [NUM_CH-1:0] ch_sw,
    input wire logic                 match_line_o,
    input wire logic                 match_line_oe_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic [DEC_LINES-1:0] dec_exp;

    // Expected active-low decode of the stored word, leftmost pair first
    always_comb begin
        dec_exp = {DEC_LINES{1'b1}};
        for (int g = 0; g < PAIR_GROUPS; g++) dec_exp[4*g + 2*stored_addr[8-2*g] + stored_addr[9-2*g]] = 1'b0;
    end

    a_decode_lines: assert property (decode_bus_n == dec_exp) else $error("decode lines wrong");
    a_clock_is_or: assert property (rx_pulse.bit_clk == (rx_pulse.one | rx_pulse.zero)) else $error("bit clock");
    a_pulse_exclusive: assert property (!(rx_pulse.one && rx_pulse.zero)) else $error("one and zero");
    a_store_hold: assert property ($changed(stored_addr) |-> addr_load) else $error("store moved");
    a_load_on_sync: assert property ($changed(stored_addr) |-> $past(rx_pulse.sync)) else $error("no sync");
    a_match_width: assert property ($fell(match_line_oe_n) |-> ##24 !match_line_oe_n ##1 match_line_oe_n)
        else $error("match pulse width");
    a_match_cause: assert property ($fell(match_line_oe_n) |-> $past(addr_load)) else $error("match cause");
    a_line_low: assert property (!match_line_o) else $error("match line level");

    // Per-channel switch ordering; a stray make before break would short transducer to amplifier
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        a_break_first: assert property ($rose(ch_sw[c].amp_conn) |-> $past(ch_sw[c].xdcr_conn) == 1'b0)
            else $error("make before break");
        a_match_code: assert property ($rose(ch_sw[c].match) |->
            stored_addr == CH_CODES[c*ADDR_BITS +: ADDR_BITS] ##1 ch_sw[c].amp_conn) else $error("bad match");
        a_idle_none: assert property (stored_addr == STORE_RST |-> !ch_sw[c].match) else $error("idle match");
    end
endmodule : sadc_core_props

bind sadc_core sadc_core_props #(.NUM_CH(NUM_CH), .CH_CODES(CH_CODES)) sadc_core_props_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .addr_sample(addr_sample), .rx_pulse(rx_pulse),
    .stored_addr(stored_addr), .decode_bus_n(decode_bus_n), .addr_load(addr_load), .ch_sw(ch_sw),
    .match_line_o(match_line_o), .match_line_oe_n(match_line_oe_n));

// *** sadc_addr_src.sv ***
`timescale 1ns/1ns
module sadc_addr_src
    import sadc_pkg::*;
(
    // Clock and request
    input wire logic                 ref_clk,
    input wire logic                 start,
    input wire logic [ADDR_BITS-1:0] word,
    input wire logic [7:0]           hold,
    // Line and status
    output logic [SAMPLE_W-1:0]      addr_sample,
    output logic                     busy
);
    localparam logic [SAMPLE_W-1:0] BIT_AMP  = 8'h28;
    localparam logic [SAMPLE_W-1:0] SYNC_AMP = 8'h50;
    logic [ADDR_BITS-1:0] w;
    logic [SAMPLE_W-1:0]  amp;
    logic                 b;

    // Nine bits leftmost-first, then the sync bit; line returns to zero between bits
    initial begin
        addr_sample = 8'h00;
        busy = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (start) begin
                #1 busy = 1'b1;
                w = word;
                for (int i = 0; i < ADDR_BITS; i++) begin
                    b = (i < SHIFT_BITS) ? w[8-i] : w[9];
                    amp = (i < SHIFT_BITS) ? BIT_AMP : SYNC_AMP;
                    addr_sample = b ? amp : (~amp + 8'h01);
                    repeat (hold) @(posedge ref_clk);
                    #1 addr_sample = 8'h00;
                    repeat (hold) @(posedge ref_clk);
                    #1;
                end
                busy = 1'b0;
            end
        end
    end
endmodule : sadc_addr_src

// *** sadc_core_tb_top.sv ***
`timescale 1ns/1ns
module sadc_core_tb_top;
    import sadc_pkg::*;
    logic                 ref_clk, rst_b, start, busy, addr_load, match_line_o, match_line_oe_n;
    logic [ADDR_BITS-1:0] word, stored_addr;
    logic [7:0]           hold;
    logic [SAMPLE_W-1:0]  addr_sample;
    logic [DEC_LINES-1:0] decode_bus_n;
    sadc_pulse_s          rx_pulse;
    sadc_sw_s [9:0]       ch_sw;
    int                   n_errors, checks_done;

    sadc_core sadc_core_i (.ref_clk(ref_clk), .rst_b(rst_b), .addr_sample(addr_sample), .rx_pulse(rx_pulse),
        .stored_addr(stored_addr), .decode_bus_n(decode_bus_n), .addr_load(addr_load), .ch_sw(ch_sw),
        .match_line_o(match_line_o), .match_line_oe_n(match_line_oe_n));
    sadc_addr_src sadc_addr_src_i (.ref_clk(ref_clk), .start(start), .word(word), .hold(hold),
        .addr_sample(addr_sample), .busy(busy));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Expected decode lines, leftmost bit pair in group 0
    function automatic logic [DEC_LINES-1:0] exp_dec(input logic [ADDR_BITS-1:0] a);
        exp_dec = {DEC_LINES{1'b1}};
        for (int g = 0; g < PAIR_GROUPS; g++) exp_dec[4*g + 2*a[8-2*g] + a[9-2*g]] = 1'b0;
    endfunction : exp_dec

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // Bounded wait; a hang ends the run with a failure
    task automatic wait_for(input bit on_load);
        int t;
        t = 0;
        while (on_load ? (addr_load !== 1'b1) : (busy !== 1'b0)) begin
            @(posedge ref_clk);
            #1 t++;
            if (t > 20000) begin
                n_errors++;
                print_verdict();
            end
        end
    endtask : wait_for

    // Send one word, then check store, decode and the channel switches in the sample phase
    task automatic send(input logic [ADDR_BITS-1:0] w, input logic [7:0] h);
        word = w;
        hold = h;
        start = 1'b1;
        @(posedge ref_clk);
        #1 start = 1'b0;
        wait_for(1'b1);
        check(stored_addr, w);
        check(decode_bus_n, exp_dec(w));
        repeat (3) @(posedge ref_clk);
        #1;
        for (int k = 0; k < 10; k++) begin
            check(ch_sw[k].amp_conn, w == k);
            check(ch_sw[k].xdcr_conn, w != k);
        end
        check(match_line_oe_n, w > 10'h009);
        check(match_line_o, 1'b0);
        check(rx_pulse, 4'h0);
        wait_for(1'b0);
    endtask : send

    initial begin
        rst_b = 1'b0;
        start = 1'b0;
        word = 10'h000;
        hold = 8'h03;
        n_errors = 0;
        checks_done = 0;
        void'($urandom(42243));
        repeat (20) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        check(stored_addr, STORE_RST);
        check(decode_bus_n, exp_dec(STORE_RST));
        for (int k = 0; k < 10; k++) check(ch_sw[k].xdcr_conn, 1'b1);
        // Corners: fastest legal hold, alternating pairs, 1 MHz bit period
        send(10'h2aa, 8'h03);
        send(10'h000, 8'h3e);
        send(10'h155, 8'h03);
        send(10'h3fe, 8'h03);
        // Channels in turn, a random non-channel word between each
        for (int i = 0; i < 24; i++) begin
            if (i % 2 == 0) send(10'((i / 2) % 10), 8'($urandom_range(3, 40)));
            else send(10'($urandom_range(10, 1022)), 8'($urandom_range(3, 40)));
        end
        print_verdict();
    end
endmodule : sadc_core_tb_top
